// ==== stc_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// - mode register reports 0 auto, 1-5, 6 standby
// - probe condition reports codes 0 to 3
// - active step 0-5, plus 10 when forced
// - mains state 0/1, or 10/11 when forced
// - heat/cool reports 0 cooling, 1 heating
// - rate select accepts 0-6, default 2
// - timeout 0-60 minutes, 0 disables, default 0
// - timeout forces step one, mains off
// - writing 1 restores defaults and self-clears together on the next cycle
// - proportional band 10-100, default 20
// - hysteresis 1-10, default 4
// - step force enable hands step to bus
// - step force value 0-5 used when enabled
// - mains force enable hands mains to bus
// - mains force value used when enabled
// - only read holding, read input, write single, multiple
// - identity read only, position 7 reads 0
module stc_regs #(
  parameter logic [15:0] VARIANT_ID  = 16'h00A5, // arbitrary
  parameter logic [15:0] HW_REV_ID   = 16'h0011, // arbitrary
  parameter logic [15:0] FW_REV_ID   = 16'h0022, // arbitrary
  parameter logic [35:0] CYC_PER_MIN = 36'(stc_pkg::CYC_PER_MIN)
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic [7:0]       rsp_exc,
  input  wire logic [2:0]  run_mode,
  input  wire logic [1:0]  probe_state,
  input  wire logic [15:0] target_temp,
  input  wire logic [15:0] measured_temp,
  input  wire logic [2:0]  regulated_step,
  input  wire logic        mains_request,
  input  wire logic        heating,
  output logic [2:0]       step_out,
  output logic             mains_out,
  output logic [15:0]      node_address,
  output logic [15:0]      rate_select,
  output logic [15:0]      parity_select,
  output logic [15:0]      termination,
  output logic [15:0]      band,
  output logic [15:0]      hysteresis
);
  logic [15:0] hreg [0:31];
  logic [15:0] next_hreg [0:31];
  logic        next_rsp_valid;
  logic [15:0] next_rsp_rdata;
  logic [7:0]  next_rsp_exc;
  logic [2:0]  next_step_out;
  logic        next_mains_out;
  logic        expired;
  logic        step_forced;
  logic        mains_forced;
  logic [4:0]  idx;
  logic        in_hold;

  function automatic logic [15:0] factory(input logic [4:0] i);
    case (i)
      stc_pkg::HR_NODE:    factory = stc_pkg::RST_NODE;
      stc_pkg::HR_RATE:    factory = stc_pkg::RST_RATE;
      stc_pkg::HR_PARITY:  factory = stc_pkg::RST_PARITY;
      stc_pkg::HR_TIMEOUT: factory = stc_pkg::RST_TIMEOUT;
      stc_pkg::HR_TERM:    factory = stc_pkg::RST_TERM;
      stc_pkg::HR_BAND:    factory = stc_pkg::RST_BAND;
      stc_pkg::HR_HYST:    factory = stc_pkg::RST_HYST;
      stc_pkg::HR_SF_EN,
      stc_pkg::HR_SF_VAL,
      stc_pkg::HR_MF_EN,
      stc_pkg::HR_MF_VAL:  factory = stc_pkg::RST_FORCE;
      default:             factory = stc_pkg::RST_RESTORE;
    endcase
  endfunction

  // out-of-range writes are refused so downstream never sees illegal codes
  function automatic logic legal(input logic [4:0] i, input logic [15:0] d);
    case (i)
      stc_pkg::HR_NODE:    legal = d >= stc_pkg::NODE_MIN && d <= stc_pkg::NODE_MAX;
      stc_pkg::HR_RATE:    legal = d <= stc_pkg::RATE_MAX;
      stc_pkg::HR_PARITY:  legal = d <= stc_pkg::PARITY_MAX;
      stc_pkg::HR_TIMEOUT: legal = d <= stc_pkg::TIMEOUT_MAX;
      stc_pkg::HR_BAND:    legal = d >= stc_pkg::BAND_MIN && d <= stc_pkg::BAND_MAX;
      stc_pkg::HR_HYST:    legal = d >= stc_pkg::HYST_MIN && d <= stc_pkg::HYST_MAX;
      stc_pkg::HR_SF_VAL:  legal = d <= stc_pkg::STEP_MAX;
      default:             legal = d <= stc_pkg::FLAG_MAX;
    endcase
  endfunction

  function automatic logic read_only(input logic [4:0] i);
    read_only = i == stc_pkg::HR_VARIANT || i == stc_pkg::HR_HW_REV ||
                i == stc_pkg::HR_FW_REV || i == stc_pkg::HR_RSVD;
  endfunction

  stc_silence_timer #(
    .CYC_PER_MIN (CYC_PER_MIN)
  ) u_timer (
    .mclk    (mclk),
    .rst     (rst),
    .traffic (req_valid),
    .minutes (hreg[stc_pkg::HR_TIMEOUT][5:0]),
    .expired (expired)
  );

  assign idx          = req_addr[4:0];
  assign in_hold      = req_addr >= 16'(stc_pkg::HR_FIRST) &&
                        req_addr <= 16'(stc_pkg::HR_LAST);
  assign step_forced  = hreg[stc_pkg::HR_SF_EN][0];
  assign mains_forced = hreg[stc_pkg::HR_MF_EN][0];

  // register file and answers
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      next_hreg[i] = hreg[i];
    end
    next_rsp_valid = req_valid;
    next_rsp_rdata = 16'h0000;
    next_rsp_exc   = stc_pkg::EXC_NONE;
    // restore lands one cycle after the write, and the flag drops itself on that same edge
    if (hreg[stc_pkg::HR_RESTORE][0]) begin
      for (int i = 0; i < 32; i++) begin
        next_hreg[i] = factory(5'(i));
      end
    end
    if (req_valid) begin
      case (req_func)
        stc_pkg::FN_READ_HOLD: begin
          if (!in_hold) begin
            next_rsp_exc = stc_pkg::EXC_ADDR;
          end else begin
            case (idx)
              stc_pkg::HR_VARIANT: next_rsp_rdata = VARIANT_ID;
              stc_pkg::HR_HW_REV:  next_rsp_rdata = HW_REV_ID;
              stc_pkg::HR_FW_REV:  next_rsp_rdata = FW_REV_ID;
              stc_pkg::HR_RSVD:    next_rsp_rdata = 16'h0000;
              default:             next_rsp_rdata = hreg[idx];
            endcase
          end
        end
        stc_pkg::FN_READ_INPUT: begin
          case (req_addr)
            stc_pkg::IR_MODE:     next_rsp_rdata = {13'h0000, run_mode};
            stc_pkg::IR_PROBE:    next_rsp_rdata = {14'h0000, probe_state};
            stc_pkg::IR_TARGET:   next_rsp_rdata = target_temp;
            stc_pkg::IR_MEASURED: next_rsp_rdata = measured_temp;
            stc_pkg::IR_STEP: begin
              next_rsp_rdata = {13'h0000, step_out};
              if (step_forced && !expired) begin
                next_rsp_rdata = {13'h0000, step_out} + stc_pkg::FORCE_MARK;
              end
            end
            stc_pkg::IR_MAINS: begin
              next_rsp_rdata = {15'h0000, mains_out};
              if (mains_forced && !expired) begin
                next_rsp_rdata = {15'h0000, mains_out} + stc_pkg::FORCE_MARK;
              end
            end
            stc_pkg::IR_HEATCOOL: next_rsp_rdata = {15'h0000, heating};
            default:              next_rsp_exc   = stc_pkg::EXC_ADDR;
          endcase
        end
        stc_pkg::FN_WRITE_SINGLE,
        stc_pkg::FN_WRITE_MULTI: begin
          next_rsp_rdata = req_wdata;
          if (!in_hold) begin
            next_rsp_exc = stc_pkg::EXC_ADDR;
          end else if (read_only(idx)) begin
            next_rsp_exc = stc_pkg::EXC_NONE;
          end else if (!legal(idx, req_wdata)) begin
            next_rsp_exc = stc_pkg::EXC_VALUE;
          end else begin
            next_hreg[idx] = req_wdata;
          end
        end
        default: next_rsp_exc = stc_pkg::EXC_FUNC;
      endcase
    end
  end

  // output drive: silence fallback outranks any bus overwrite
  always_comb begin
    if (expired) begin
      next_step_out  = stc_pkg::FALLBACK_STEP;
      next_mains_out = 1'b0;
    end else begin
      next_step_out  = regulated_step;
      next_mains_out = mains_request;
      if (step_forced) begin
        next_step_out = hreg[stc_pkg::HR_SF_VAL][2:0];
      end
      if (mains_forced) begin
        next_mains_out = hreg[stc_pkg::HR_MF_VAL][0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        hreg[i] <= factory(5'(i));
      end
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_exc   <= stc_pkg::EXC_NONE;
      step_out  <= 3'h0;
      mains_out <= 1'b0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        hreg[i] <= next_hreg[i];
      end
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      rsp_exc   <= next_rsp_exc;
      step_out  <= next_step_out;
      mains_out <= next_mains_out;
    end
  end

  // settings leave through flops of their own
  always_ff @(posedge mclk) begin
    if (rst) begin
      node_address  <= stc_pkg::RST_NODE;
      rate_select   <= stc_pkg::RST_RATE;
      parity_select <= stc_pkg::RST_PARITY;
      termination   <= stc_pkg::RST_TERM;
      band          <= stc_pkg::RST_BAND;
      hysteresis    <= stc_pkg::RST_HYST;
    end else begin
      node_address  <= next_hreg[stc_pkg::HR_NODE];
      rate_select   <= next_hreg[stc_pkg::HR_RATE];
      parity_select <= next_hreg[stc_pkg::HR_PARITY];
      termination   <= next_hreg[stc_pkg::HR_TERM];
      band          <= next_hreg[stc_pkg::HR_BAND];
      hysteresis    <= next_hreg[stc_pkg::HR_HYST];
    end
  end

  a_answer_next: assert property (@(posedge mclk) disable iff (rst)
    req_valid |=> rsp_valid)
    else $error("request not answered next cycle");

  a_bad_function: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func != stc_pkg::FN_READ_HOLD &&
    req_func != stc_pkg::FN_READ_INPUT && req_func != stc_pkg::FN_WRITE_SINGLE &&
    req_func != stc_pkg::FN_WRITE_MULTI |=> rsp_exc == stc_pkg::EXC_FUNC)
    else $error("unknown function not refused");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_HOLD &&
    req_addr == 16'(stc_pkg::HR_RSVD) |=> rsp_rdata == 16'h0000)
    else $error("reserved register not zero");

  a_ident_fixed: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_HOLD &&
    req_addr == 16'(stc_pkg::HR_VARIANT) |=> rsp_rdata == VARIANT_ID)
    else $error("identity register changed by write");

  a_restore_clear: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_RESTORE][0] && !req_valid |=>
    hreg[stc_pkg::HR_RESTORE] == 16'h0000 && hreg[stc_pkg::HR_BAND] == stc_pkg::RST_BAND &&
    hreg[stc_pkg::HR_RATE] == stc_pkg::RST_RATE && hreg[stc_pkg::HR_HYST] == stc_pkg::RST_HYST)
    else $error("restore did not load defaults and clear");

  a_rate_range: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_RATE] <= stc_pkg::RATE_MAX)
    else $error("rate select out of range");

  a_timeout_range: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_TIMEOUT] <= stc_pkg::TIMEOUT_MAX)
    else $error("timeout out of range");

  a_band_range: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_BAND] >= stc_pkg::BAND_MIN && hreg[stc_pkg::HR_BAND] <= stc_pkg::BAND_MAX)
    else $error("band out of range");

  a_silence_fallback: assert property (@(posedge mclk) disable iff (rst)
    expired [*2] |-> step_out == stc_pkg::FALLBACK_STEP && !mains_out)
    else $error("fallback not applied");

  a_step_force: assert property (@(posedge mclk) disable iff (rst)
    !expired && step_forced |=> step_out == $past(hreg[stc_pkg::HR_SF_VAL][2:0]))
    else $error("step overwrite not applied");

  a_step_auto: assert property (@(posedge mclk) disable iff (rst)
    !expired && !step_forced |=> step_out == $past(regulated_step))
    else $error("regulated step not followed");

  a_mains_force: assert property (@(posedge mclk) disable iff (rst)
    !expired && mains_forced |=> mains_out == $past(hreg[stc_pkg::HR_MF_VAL][0]))
    else $error("mains overwrite not applied");

  a_mode_report: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_INPUT && req_addr == stc_pkg::IR_MODE
    |=> rsp_rdata == {13'h0000, $past(run_mode)})
    else $error("mode readback wrong");

  a_probe_report: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_INPUT && req_addr == stc_pkg::IR_PROBE
    |=> rsp_rdata == {14'h0000, $past(probe_state)})
    else $error("probe readback wrong");

  a_heat_report: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_INPUT && req_addr == stc_pkg::IR_HEATCOOL
    |=> rsp_rdata == {15'h0000, $past(heating)})
    else $error("heat/cool readback wrong");

  a_step_report: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_INPUT && req_addr == stc_pkg::IR_STEP &&
    step_forced && !expired |=> rsp_rdata == {13'h0000, $past(step_out)} + stc_pkg::FORCE_MARK)
    else $error("forced step readback lacks mark");

  a_mains_report: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_INPUT && req_addr == stc_pkg::IR_MAINS &&
    mains_forced && !expired |=> rsp_rdata == {15'h0000, $past(mains_out)} + stc_pkg::FORCE_MARK)
    else $error("forced mains readback lacks mark");

  a_hyst_range: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_HYST] >= stc_pkg::HYST_MIN && hreg[stc_pkg::HR_HYST] <= stc_pkg::HYST_MAX)
    else $error("hysteresis out of range");

  a_step_value: assert property (@(posedge mclk) disable iff (rst)
    hreg[stc_pkg::HR_SF_VAL] <= stc_pkg::STEP_MAX)
    else $error("step overwrite value out of range");

  a_mains_auto: assert property (@(posedge mclk) disable iff (rst)
    !expired && !mains_forced |=> mains_out == $past(mains_request))
    else $error("regulator mains request not followed");

  a_addr_refused: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_HOLD && !in_hold
    |=> rsp_exc == stc_pkg::EXC_ADDR)
    else $error("holding address outside map not refused");

  a_fw_fixed: assert property (@(posedge mclk) disable iff (rst)
    req_valid && req_func == stc_pkg::FN_READ_HOLD &&
    req_addr == 16'(stc_pkg::HR_FW_REV) |=> rsp_rdata == FW_REV_ID)
    else $error("firmware revision readback wrong");
endmodule

// ==== stc_pkg.sv ====
package stc_pkg;
  // request function codes
  localparam logic [7:0] FN_READ_HOLD    = 8'h03;
  localparam logic [7:0] FN_READ_INPUT   = 8'h04;
  localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FN_WRITE_MULTI  = 8'h10;

  // answer codes, zero means accepted
  localparam logic [7:0] EXC_NONE  = 8'h00;
  localparam logic [7:0] EXC_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ADDR  = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // holding register offsets
  localparam logic [4:0] HR_NODE    = 5'h01;
  localparam logic [4:0] HR_RATE    = 5'h02;
  localparam logic [4:0] HR_PARITY  = 5'h03;
  localparam logic [4:0] HR_VARIANT = 5'h04;
  localparam logic [4:0] HR_HW_REV  = 5'h05;
  localparam logic [4:0] HR_FW_REV  = 5'h06;
  localparam logic [4:0] HR_RSVD    = 5'h07;
  localparam logic [4:0] HR_TIMEOUT = 5'h08;
  localparam logic [4:0] HR_TERM    = 5'h09;
  localparam logic [4:0] HR_RESTORE = 5'h0A;
  localparam logic [4:0] HR_BAND    = 5'h0B;
  localparam logic [4:0] HR_HYST    = 5'h0C;
  localparam logic [4:0] HR_SF_EN   = 5'h0D;
  localparam logic [4:0] HR_SF_VAL  = 5'h0E;
  localparam logic [4:0] HR_MF_EN   = 5'h0F;
  localparam logic [4:0] HR_MF_VAL  = 5'h10;
  localparam logic [4:0] HR_FIRST   = HR_NODE;
  localparam logic [4:0] HR_LAST    = HR_MF_VAL;

  // input register offsets
  localparam logic [15:0] IR_MODE     = 16'h0001;
  localparam logic [15:0] IR_PROBE    = 16'h0002;
  localparam logic [15:0] IR_TARGET   = 16'h0003;
  localparam logic [15:0] IR_MEASURED = 16'h0004;
  localparam logic [15:0] IR_STEP     = 16'h0005;
  localparam logic [15:0] IR_MAINS    = 16'h0006;
  localparam logic [15:0] IR_HEATCOOL = 16'h0007;

  // factory values
  localparam logic [15:0] RST_NODE    = 16'h0001;
  localparam logic [15:0] RST_RATE    = 16'h0002;
  localparam logic [15:0] RST_PARITY  = 16'h0001;
  localparam logic [15:0] RST_TIMEOUT = 16'h0000;
  localparam logic [15:0] RST_TERM    = 16'h0000;
  localparam logic [15:0] RST_RESTORE = 16'h0000;
  localparam logic [15:0] RST_BAND    = 16'h0014;
  localparam logic [15:0] RST_HYST    = 16'h0004;
  localparam logic [15:0] RST_FORCE   = 16'h0000;

  // legal ranges
  localparam logic [15:0] NODE_MIN    = 16'h0001;
  localparam logic [15:0] NODE_MAX    = 16'h00F7;
  localparam logic [15:0] RATE_MAX    = 16'h0006;
  localparam logic [15:0] PARITY_MAX  = 16'h0002;
  localparam logic [15:0] TIMEOUT_MAX = 16'h003C;
  localparam logic [15:0] FLAG_MAX    = 16'h0001;
  localparam logic [15:0] BAND_MIN    = 16'h000A;
  localparam logic [15:0] BAND_MAX    = 16'h0064;
  localparam logic [15:0] HYST_MIN    = 16'h0001;
  localparam logic [15:0] HYST_MAX    = 16'h000A;
  localparam logic [15:0] STEP_MAX    = 16'h0005;

  // status encodings
  localparam logic [15:0] FORCE_MARK    = 16'h000A;
  localparam logic [2:0]  FALLBACK_STEP = 3'h1;

  // timing
  localparam longint unsigned MCLK_HZ     = 64'd200_000_000;
  localparam longint unsigned SEC_PER_MIN = 64'd60;
  localparam longint unsigned CYC_PER_MIN = MCLK_HZ * SEC_PER_MIN;
endpackage

// ==== stc_silence_timer.sv ====
`timescale 1ns/1ps
module stc_silence_timer #(
  parameter logic [35:0] CYC_PER_MIN = 36'(stc_pkg::CYC_PER_MIN)
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       traffic,
  input  wire logic [5:0] minutes,
  output logic            expired
);
  logic [35:0] pre;
  logic [5:0]  mins;
  logic [35:0] next_pre;
  logic [5:0]  next_mins;
  logic        next_expired;

  // any traffic restarts the whole wait; zero minutes disables it
  always_comb begin
    next_pre     = pre;
    next_mins    = mins;
    next_expired = expired;
    if (traffic || minutes == 6'h00) begin
      next_pre     = 36'h0_0000_0000;
      next_mins    = 6'h00;
      next_expired = 1'b0;
    end else if (!expired) begin
      if (pre == CYC_PER_MIN - 36'h0_0000_0001) begin
        next_pre = 36'h0_0000_0000;
        if (mins + 6'h01 >= minutes) begin
          next_expired = 1'b1;
        end else begin
          next_mins = mins + 6'h01;
        end
      end else begin
        next_pre = pre + 36'h0_0000_0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre     <= 36'h0_0000_0000;
      mins    <= 6'h00;
      expired <= 1'b0;
    end else begin
      pre     <= next_pre;
      mins    <= next_mins;
      expired <= next_expired;
    end
  end
endmodule

// ==== stc_master_model.sv ====
`timescale 1ns/1ps
// bus master side: one word per request, answer loaded by the taking edge itself
module stc_master_model (
  input  wire logic        mclk,
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_rdata,
  input  wire logic [7:0]  rsp_exc
);
  initial begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic [7:0] ex);
    @(negedge mclk);
    req_valid = 1'b1;
    req_func  = f;
    req_addr  = a;
    req_wdata = d;
    @(negedge mclk);
    // answer stands only between the taking edge and the next one
    rd = rsp_rdata;
    // a missing answer shows as an impossible code
    ex = (rsp_valid === 1'b1) ? rsp_exc : 8'hFF;
    // released fields flip so a stale value cannot pass for a live one
    req_valid = 1'b0;
    req_func  = ~f;
    req_addr  = ~a;
    req_wdata = ~d;
    @(negedge mclk);
  endtask
endmodule

// ==== staged_thermostat_regs_test.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module staged_thermostat_regs_test;
  localparam logic [15:0] VAR_ID = 16'h005A; // arbitrary
  localparam logic [15:0] HW_ID  = 16'h0033; // arbitrary
  localparam logic [15:0] FW_ID  = 16'h0044; // arbitrary
  localparam logic [7:0]  RH     = stc_pkg::FN_READ_HOLD;
  localparam logic [7:0]  RI     = stc_pkg::FN_READ_INPUT;
  localparam logic [7:0]  WS     = stc_pkg::FN_WRITE_SINGLE;
  localparam logic [7:0]  WM     = stc_pkg::FN_WRITE_MULTI;

  logic        mclk, rst, req_valid, rsp_valid, mains_request, heating, mains_out;
  logic [7:0]  req_func, rsp_exc;
  logic [15:0] req_addr, req_wdata, rsp_rdata, target_temp, measured_temp;
  logic [2:0]  run_mode, regulated_step, step_out;
  logic [1:0]  probe_state;
  logic [15:0] node_address, rate_select, parity_select, termination, band, hysteresis;
  logic [15:0] shadow [1:16];
  int          n_mismatch, total_checks, cyc;

  stc_regs #(.VARIANT_ID(VAR_ID), .HW_REV_ID(HW_ID), .FW_REV_ID(FW_ID),
             .CYC_PER_MIN(36'h0_0000_0014)) i_stc_regs (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc), .run_mode(run_mode),
    .probe_state(probe_state), .target_temp(target_temp), .measured_temp(measured_temp),
    .regulated_step(regulated_step), .mains_request(mains_request), .heating(heating),
    .step_out(step_out), .mains_out(mains_out), .node_address(node_address),
    .rate_select(rate_select), .parity_select(parity_select), .termination(termination),
    .band(band), .hysteresis(hysteresis));

  stc_master_model i_stc_master_model (
    .mclk(mclk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_exc(rsp_exc));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // run is a few hundred cycles; ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                     input logic [7:0] e, input logic [15:0] exp_rd);
    logic [15:0] rd;
    logic [7:0]  ex;
    i_stc_master_model.xfer(f, a, d, rd, ex);
    `CHK(ex, e)
    `CHK(rd, exp_rd)
  endtask

  task automatic wr(input logic [7:0] f, input logic [4:0] a, input logic [15:0] d,
                    input logic [7:0] e);
    // every write answer echoes the data, refused or not
    req(f, 16'(a), d, e, d);
    // identity and reserved places keep their value
    if (e == 8'h00 && (a < 5'h04 || a > 5'h07)) shadow[a] = d;
  endtask

  task automatic load_factory;
    shadow = '{16'h0001, 16'h0002, 16'h0001, VAR_ID, HW_ID, FW_ID, 16'h0000, 16'h0000,
               16'h0000, 16'h0000, 16'h0014, 16'h0004, 16'h0000, 16'h0000, 16'h0000,
               16'h0000};
  endtask

  task automatic check_all;
    for (int a = 1; a <= 16; a++) req(RH, 16'(a), 16'h0000, 8'h00, shadow[a]);
  endtask

  initial begin
    rst = 1'b1;
    {run_mode, probe_state, regulated_step, mains_request, heating} = '0;
    target_temp = 16'h00FA;
    measured_temp = 16'hFFCE;
    load_factory;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    check_all;
    wr(WS, stc_pkg::HR_BAND, 16'h0009, 8'h03);
    wr(WS, stc_pkg::HR_BAND, 16'h000A, 8'h00);
    wr(WS, stc_pkg::HR_BAND, 16'h0064, 8'h00);
    wr(WS, stc_pkg::HR_BAND, 16'h0065, 8'h03);
    wr(WS, stc_pkg::HR_HYST, 16'h0000, 8'h03);
    wr(WS, stc_pkg::HR_HYST, 16'h000A, 8'h00);
    wr(WS, stc_pkg::HR_HYST, 16'h000B, 8'h03);
    wr(WS, stc_pkg::HR_RATE, 16'h0005, 8'h00);
    wr(WS, stc_pkg::HR_RATE, 16'h0007, 8'h03);
    wr(WS, stc_pkg::HR_TIMEOUT, 16'h003D, 8'h03);
    wr(WS, stc_pkg::HR_SF_VAL, 16'h0006, 8'h03);
    wr(WS, stc_pkg::HR_MF_VAL, 16'h0002, 8'h03);
    wr(WS, stc_pkg::HR_RESTORE, 16'h0002, 8'h03);
    for (int a = 4; a <= 7; a++) wr(WS, 5'(a), 16'h1234, 8'h00);
    wr(WM, stc_pkg::HR_BAND, 16'h0032, 8'h00);
    wr(WM, stc_pkg::HR_HYST, 16'h0007, 8'h00);
    wr(WS, stc_pkg::HR_NODE, 16'h00F7, 8'h00);
    wr(WS, stc_pkg::HR_PARITY, 16'h0002, 8'h00);
    wr(WS, stc_pkg::HR_TERM, 16'h0001, 8'h00);
    check_all;
    `CHK(band, 16'h0032)
    `CHK(hysteresis, 16'h0007)
    `CHK(rate_select, 16'h0005)
    `CHK(node_address, 16'h00F7)
    `CHK(parity_select, 16'h0002)
    `CHK(termination, 16'h0001)
    req(8'h05, 16'h0001, 16'h0000, 8'h01, 16'h0000);
    req(RH, 16'h0000, 16'h0000, 8'h02, 16'h0000);
    req(RH, 16'h0011, 16'h0000, 8'h02, 16'h0000);
    req(WS, 16'h0011, 16'h0001, 8'h02, 16'h0001);
    req(RI, 16'h0008, 16'h0000, 8'h02, 16'h0000);
    for (int i = 0; i <= 6; i++) begin
      run_mode = 3'(i);
      req(RI, stc_pkg::IR_MODE, 16'h0000, 8'h00, 16'(i));
    end
    for (int i = 0; i <= 3; i++) begin
      probe_state = 2'(i);
      req(RI, stc_pkg::IR_PROBE, 16'h0000, 8'h00, 16'(i));
    end
    req(RI, stc_pkg::IR_TARGET, 16'h0000, 8'h00, 16'h00FA);
    req(RI, stc_pkg::IR_MEASURED, 16'h0000, 8'h00, 16'hFFCE);
    for (int i = 0; i <= 1; i++) begin
      heating = 1'(i);
      req(RI, stc_pkg::IR_HEATCOOL, 16'h0000, 8'h00, 16'(i));
    end
    regulated_step = 3'h2;
    mains_request = 1'b1;
    req(RI, stc_pkg::IR_STEP, 16'h0000, 8'h00, 16'h0002);
    req(RI, stc_pkg::IR_MAINS, 16'h0000, 8'h00, 16'h0001);
    wr(WS, stc_pkg::HR_SF_VAL, 16'h0003, 8'h00);
    `CHK(step_out, 3'h2)
    wr(WS, stc_pkg::HR_SF_EN, 16'h0001, 8'h00);
    `CHK(step_out, 3'h3)
    req(RI, stc_pkg::IR_STEP, 16'h0000, 8'h00, 16'h000D);
    wr(WS, stc_pkg::HR_MF_EN, 16'h0001, 8'h00);
    `CHK(mains_out, 1'b0)
    req(RI, stc_pkg::IR_MAINS, 16'h0000, 8'h00, 16'h000A);
    wr(WS, stc_pkg::HR_MF_VAL, 16'h0001, 8'h00);
    `CHK(mains_out, 1'b1)
    req(RI, stc_pkg::IR_MAINS, 16'h0000, 8'h00, 16'h000B);
    // one minute is 20 cycles here; silence starts after this write
    wr(WS, stc_pkg::HR_TIMEOUT, 16'h0001, 8'h00);
    repeat (10) @(negedge mclk);
    `CHK(step_out, 3'h3)
    repeat (20) @(negedge mclk);
    `CHK(step_out, 3'h1)
    `CHK(mains_out, 1'b0)
    wr(WS, stc_pkg::HR_RESTORE, 16'h0001, 8'h00);
    load_factory;
    check_all;
    `CHK(step_out, 3'h2)
    `CHK(mains_out, 1'b1)
    `CHK(band, 16'h0014)
    `CHK(hysteresis, 16'h0004)
    `CHK(rate_select, 16'h0002)
    `CHK(node_address, 16'h0001)
    `CHK(parity_select, 16'h0001)
    `CHK(termination, 16'h0000)
    finish_test;
  end
endmodule
